/* File: src/spi_block_pkg.sv */
package spi_block_pkg;

    // bus clock 200 MHz; the master serial clock is this clock divided by two
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned SCLK_DIVIDE   = 2;
    localparam int unsigned SCLK_PERIOD_PS = CLK_PERIOD_PS * SCLK_DIVIDE;

    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned BUF_DEPTH = 2;

    localparam logic [3:0] LAST_HALF  = 4'hf;
    localparam logic [3:0] LAST_BIT   = 4'h7;
    localparam logic [1:0] BUF_FULL   = 2'h2;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        IDLE = 2'b01,
        XFER = 2'b10
    } master_state_type;

    typedef struct packed {
        master_state_type mst;
        logic             div;
        logic             enQ;
        logic [3:0]       half;
        logic [3:0]       bits;
        logic [7:0]       shifter;
        logic [7:0]       hold;
        logic             holdValid;
        logic [7:0]       rxBuf;
        logic             outBit;
        logic             prevSclk;
        logic             prevSs;
        logic             slvBusy;
        logic             shEmpty;
        logic             txEmpty;
        logic             rxFull;
        logic             byteDone;
        logic             overrun;
        logic             armed;
        logic             irq;
        logic             donePending;
        logic             sclk;
        logic             sclkOeN;
        logic             mosi;
        logic             miso;
    } state_type;

    localparam state_type RESET_STATE = '{
        mst:     IDLE,
        shEmpty: 1'b1,
        sclkOeN: 1'b1,
        miso:    1'b1,
        default: '0
    };

    typedef struct packed {
        logic [7:0] head;
        logic [7:0] tail;
        logic [1:0] count;
        logic       ready;
    } buffer_state_type;

    localparam buffer_state_type BUF_RESET = '{
        head:    RESET_BYTE,
        tail:    RESET_BYTE,
        count:   2'h0,
        ready:   1'b1
    };

endpackage : spi_block_pkg

/* File: src/two_entry_buffer.sv */
`timescale 1ns/1ps
module two_entry_buffer (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] inData,
    input  wire logic       inValid,
    output logic            inReady,
    output logic [7:0]      outData,
    output logic            outValid,
    input  wire logic       outReady
);

    spi_block_pkg::buffer_state_type s;
    spi_block_pkg::buffer_state_type n;
    logic                            push;
    logic                            pop;

    // ready is registered so the writer never sees a combinational path
    always_comb begin
        n    = s;
        push = inValid & s.ready;
        pop  = outReady & (s.count != 2'h0);
        case ({push, pop})
            2'b10: begin
                if (s.count == 2'h0) begin
                    n.head = inData;
                end else begin
                    n.tail = inData;
                end
                n.count = s.count + 2'h1;
            end
            2'b01: begin
                n.head  = s.tail;
                n.count = s.count - 2'h1;
            end
            2'b11: begin
                if (s.count == 2'h1) begin
                    n.head = inData;
                end else begin
                    n.head = s.tail;
                    n.tail = inData;
                end
            end
            default: begin
                n.count = s.count;
            end
        endcase
        n.ready = (n.count != spi_block_pkg::BUF_FULL);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= spi_block_pkg::BUF_RESET;
        end else begin
            s <= n;
        end
    end

    assign inReady  = s.ready;
    assign outData  = s.head;
    assign outValid = (s.count != 2'h0);

endmodule : two_entry_buffer

/* File: src/spi_block.sv */
// What this block does
// - phase 0: sample leading, change trailing
// - phase 1: change leading, sample trailing
// - polarity 1 idles clock high, else low
// - four SPI mode numbers accepted
// - master output shows chosen shifter end bit
// - divider goes to one then toggles
// - master disable idles pins, resets state
// - master write loads shifter and starts transfer
// - waiting byte follows last bit immediately
// - tx empty on enable, irq armed later
// - rx full on eighth capture, read clears
// - byte done timing depends on mode
// - overrun flagged half clock before rx full
// - slave drives MISO only enabled and selected
// - slave keeps auxiliary output tri-stated
// - slave disable idles MISO, resets state
// - slave select from pin or firmware
// - negated select resets slave, ignores lines
// - slave loads shifter only when free
// - modes 0/1 transfer starts at select
// - modes 2/3 transfer starts at leading edge
`timescale 1ns/1ps
module spi_block (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       enable,
    input  wire logic       masterMode,
    input  wire logic [1:0] spiMode,
    input  wire logic       lsbFirst,
    input  wire logic [1:0] auxPinSelect,
    input  wire logic       auxFirmwareSelectEnable,
    input  wire logic [3:0] auxIn,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    output logic            txReady,
    input  wire logic       rxRead,
    input  wire logic       statusRead,
    output logic [7:0]      rxData,
    output logic            txEmpty,
    output logic            rxFull,
    output logic            byteDone,
    output logic            rxOverflow,
    output logic            txEmptyIrq,
    input  wire logic       sclkIn,
    output logic            sclkOut,
    output logic            sclkOeN,
    input  wire logic       mosiIn,
    output logic            mosiOut,
    input  wire logic       misoIn,
    output logic            misoOut
);

    spi_block_pkg::state_type s;
    spi_block_pkg::state_type n;

    logic       pol;
    logic       pha;
    logic       ssActive;
    logic       lead;
    logic       trail;
    logic       inBit;
    logic       sampleNow;
    logic       changeNow;
    logic       capture;
    logic       loadNow;
    logic       popReady;
    logic [7:0] bufData;
    logic       bufValid;

    function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic lsb, input logic b);
        shiftIn = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shiftIn

    function automatic logic endBit(input logic [7:0] v, input logic lsb);
        endBit = lsb ? v[0] : v[7];
    endfunction : endBit

    // staging ahead of tx_buffer so a burst of writes is held, not dropped
    two_entry_buffer txStage (
        .clk      (clk),
        .reset_n  (reset_n),
        .inData   (txData),
        .inValid  (txValid),
        .inReady  (txReady),
        .outData  (bufData),
        .outValid (bufValid),
        .outReady (popReady)
    );

    always_comb begin
        n         = s;
        pol       = spiMode[1];
        pha       = spiMode[0];
        sampleNow = 1'b0;
        changeNow = 1'b0;
        capture   = 1'b0;
        loadNow   = 1'b0;
        lead      = 1'b0;
        trail     = 1'b0;
        inBit     = misoIn;
        // firmware select drives the slave select itself when enabled
        ssActive  = auxFirmwareSelectEnable ? ~auxPinSelect[0] : ~auxIn[auxPinSelect];
        n.enQ     = enable;
        n.prevSs  = ssActive;
        // first enabled cycle never pops, so tx empty shows at once
        popReady  = s.enQ & enable & ~s.holdValid;

        if (bufValid && popReady) begin
            n.hold      = bufData;
            n.holdValid = 1'b1;
        end

        // clears first; any set below in the same cycle wins
        if (statusRead) begin
            n.byteDone = 1'b0;
            n.overrun  = 1'b0;
        end
        if (rxRead) begin
            n.rxFull = 1'b0;
        end
        n.donePending = 1'b0;
        if (s.donePending) begin
            n.byteDone = 1'b1;
        end

        if (masterMode) begin
            n.slvBusy = 1'b0;
            n.div     = ~s.div;
            case (s.mst)
                spi_block_pkg::IDLE: begin
                    n.sclk = pol;
                    // start aligned with the divider so edges follow the bit clock
                    if (s.holdValid && s.div) begin
                        loadNow = 1'b1;
                        n.mst   = spi_block_pkg::XFER;
                        n.bits  = 4'h0;
                    end
                end
                spi_block_pkg::XFER: begin
                    n.half = s.half + 4'h1;
                    if (!s.half[0]) begin
                        n.sclk    = ~pol;
                        changeNow = pha;
                        sampleNow = ~pha;
                    end else begin
                        n.sclk    = pol;
                        changeNow = ~pha;
                        sampleNow = pha;
                    end
                    if (s.half == spi_block_pkg::LAST_HALF) begin
                        if (s.holdValid) begin
                            loadNow = 1'b1;
                        end else begin
                            n.mst = spi_block_pkg::IDLE;
                        end
                    end
                end
                default: begin
                    n.mst = spi_block_pkg::IDLE;
                end
            endcase
        end else begin
            n.mst      = spi_block_pkg::IDLE;
            n.div      = 1'b0;
            n.half     = 4'h0;
            n.sclk     = pol;
            inBit      = mosiIn;
            n.prevSclk = sclkIn;
            lead       = (sclkIn != s.prevSclk) && (sclkIn != pol);
            trail      = (sclkIn != s.prevSclk) && (sclkIn == pol);
            if (!ssActive) begin
                n.slvBusy = 1'b0;
                n.bits    = 4'h0;
            end else begin
                if (!pol && !s.prevSs) begin
                    n.slvBusy = 1'b1;
                end
                if (lead) begin
                    n.slvBusy = 1'b1;
                end
                changeNow = pha ? lead : trail;
                sampleNow = pha ? trail : lead;
            end
            // byte must already sit in tx_buffer before the partner starts
            if (!s.slvBusy && s.shEmpty && s.holdValid && !(lead && ssActive)) begin
                loadNow = 1'b1;
            end
        end

        if (sampleNow) begin
            n.shifter = shiftIn(s.shifter, lsbFirst, inBit);
            n.bits    = s.bits + 4'h1;
            if (s.bits == spi_block_pkg::LAST_BIT) begin
                capture = 1'b1;
            end
        end
        if (changeNow) begin
            n.outBit = endBit(s.shifter, lsbFirst);
            // rx_buffer is a latch in spirit: overrun shows one edge early
            if (s.bits == spi_block_pkg::LAST_BIT && s.rxFull) begin
                n.overrun = 1'b1;
            end
        end
        if (capture) begin
            n.rxBuf   = n.shifter;
            n.rxFull  = 1'b1;
            n.bits    = 4'h0;
            n.slvBusy = 1'b0;
            n.shEmpty = 1'b1;
            if (pol) begin
                n.byteDone = 1'b1;
            end else begin
                n.donePending = 1'b1;
            end
        end
        if (loadNow) begin
            n.shifter   = s.hold;
            n.outBit    = endBit(s.hold, lsbFirst);
            n.holdValid = 1'b0;
            n.shEmpty   = 1'b0;
            n.armed     = 1'b1;
        end

        if (!enable) begin
            n.mst         = spi_block_pkg::IDLE;
            n.div         = 1'b0;
            n.half        = 4'h0;
            n.bits        = 4'h0;
            n.holdValid   = 1'b0;
            n.slvBusy     = 1'b0;
            n.shEmpty     = 1'b1;
            n.rxFull      = 1'b0;
            n.byteDone    = 1'b0;
            n.overrun     = 1'b0;
            n.armed       = 1'b0;
            n.donePending = 1'b0;
            n.sclk        = pol;
            n.outBit      = endBit(s.shifter, lsbFirst);
        end

        n.txEmpty = enable & ~n.holdValid;
        n.irq     = n.txEmpty & n.armed;
        n.sclkOeN = ~masterMode;
        n.mosi    = n.outBit;
        n.miso    = (!masterMode && enable && ssActive) ? n.outBit : 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= spi_block_pkg::RESET_STATE;
        end else begin
            s <= n;
        end
    end

    assign rxData     = s.rxBuf;
    assign txEmpty    = s.txEmpty;
    assign rxFull     = s.rxFull;
    assign byteDone   = s.byteDone;
    assign rxOverflow = s.overrun;
    assign txEmptyIrq = s.irq;
    assign sclkOut    = s.sclk;
    assign sclkOeN    = s.sclkOeN;
    assign mosiOut    = s.mosi;
    assign misoOut    = s.miso;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence enRise;
        !enable ##1 enable;
    endsequence

    sequence capLowIdle;
        (capture && enable && !spiMode[1]) ##1 (enable && !spiMode[1]);
    endsequence

    a_miso_idle: assert property (!(enable && !masterMode && ssActive) |=> misoOut)
        else $error("miso not idle high while unselected");
    a_aux_tristate: assert property (!masterMode |=> sclkOeN)
        else $error("aux output driven in slave mode");
    a_clk_idle: assert property ((masterMode && !enable) |=> sclkOut == $past(spiMode[1]))
        else $error("serial clock not at idle level");
    a_div_start: assert property ((enRise ##0 masterMode) |=> s.div)
        else $error("divider not one after enable");
    a_div_toggle: assert property ((enable && masterMode) ##1 enable |-> s.div != $past(s.div))
        else $error("divider not toggling");
    a_tx_empty_on: assert property (enRise |=> txEmpty)
        else $error("tx empty not set on enable");
    a_irq_masked: assert property (enRise |=> !txEmptyIrq)
        else $error("tx empty interrupt on enable");
    a_rx_full_set: assert property ((capture && enable) |=> rxFull)
        else $error("rx full not set on capture");
    a_rx_full_clear: assert property ((rxRead && !capture) |=> !rxFull)
        else $error("rx full not cleared by read");
    a_done_high_idle: assert property ((capture && enable && spiMode[1]) |=> byteDone)
        else $error("byte done late in modes 2 and 3");
    a_done_low_idle: assert property (capLowIdle |=> byteDone)
        else $error("byte done not half clock after rx full");

endmodule : spi_block

/* File: verification/spi_far_end.sv */
`timescale 1ns/1ps
module spi_far_end (
    input  wire logic       clk,
    input  wire logic       pol,
    input  wire logic       pha,
    input  wire logic       lsb,
    input  wire logic       sclkOut,
    input  wire logic       mosiOut,
    input  wire logic       misoOut,
    input  wire logic [7:0] slvTx,
    output logic            misoIn,
    output logic [7:0]      slvRx,
    output logic            sclkIn,
    output logic            mosiIn,
    output logic            ssN
);
    int idx = 0;
    initial begin
        misoIn = 1'b0;
        slvRx  = 8'h00;
        sclkIn = 1'b0;
        mosiIn = 1'b0;
        ssN    = 1'b1;
    end
    function automatic int pos(input int i);
        return lsb ? i : 7 - i;
    endfunction : pos
    // config changes move the idle clock level, so the bit count is restarted by hand
    task automatic rearm();
        idx = 0;
        misoIn = slvTx[pos(0)];
    endtask : rearm
    // slave role: act 1 ns after each edge, so 1 ns of hold margin is granted beyond the edge
    always @(sclkOut) begin
        #1;
        if ((sclkOut != pol) == pha) begin
            misoIn = slvTx[pos(idx)];
        end else begin
            slvRx[pos(idx)] = mosiOut;
            idx = (idx + 1) % 8;
        end
    end
    // master role: clock stands at its idle level outside frames
    task automatic master_xfer(input logic [7:0] tx, output logic [7:0] rx);
        sclkIn = pol;
        @(negedge clk);
        ssN = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (!pha) mosiIn = tx[pos(i)];
            repeat (4) @(negedge clk);
            sclkIn = ~pol;
            if (pha) mosiIn = tx[pos(i)];
            else rx[pos(i)] = misoOut;
            repeat (4) @(negedge clk);
            sclkIn = pol;
            if (pha) rx[pos(i)] = misoOut;
        end
        repeat (4) @(negedge clk);
        ssN = 1'b1;
        mosiIn = ~mosiIn;
    endtask : master_xfer
endmodule : spi_far_end

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [1:0] mode;
        logic       lsb;
        logic [7:0] tx;
        logic [7:0] sl;
    } row_type;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       enable = 1'b0;
    logic       masterMode = 1'b1;
    logic [1:0] spiMode = 2'h0;
    logic       lsbFirst = 1'b0;
    logic [1:0] auxPinSelect = 2'h0;
    logic       auxFirmwareSelectEnable = 1'b0;
    logic [7:0] txData = 8'h00;
    logic       txValid = 1'b0;
    logic       rxRead = 1'b0;
    logic       statusRead = 1'b0;
    logic [7:0] slvTx = 8'h00;
    logic [3:0] auxIn;
    logic [7:0] rxData, slvRx, mRx;
    logic       txReady, txEmpty, rxFull, byteDone, rxOverflow, txEmptyIrq;
    logic       sclkIn, sclkOut, sclkOeN, mosiIn, mosiOut, misoIn, misoOut, ssN;
    int         n_errors = 0;
    int         checks_done = 0;
    row_type    rows [8] = '{'{2'h0, 1'b0, 8'ha5, 8'h3c}, '{2'h1, 1'b0, 8'h81, 8'h7e},
                             '{2'h2, 1'b0, 8'h01, 8'h80}, '{2'h3, 1'b0, 8'hc3, 8'h5a},
                             '{2'h0, 1'b1, 8'h12, 8'hf0}, '{2'h1, 1'b1, 8'hfe, 8'h01},
                             '{2'h2, 1'b1, 8'h69, 8'h96}, '{2'h3, 1'b1, 8'h0f, 8'he7}};

    always #2.5 clk = ~clk;
    // only the chosen select pin follows the far end; the others stay negated
    assign auxIn = ~({3'h0, ~ssN} << auxPinSelect);

    spi_block i_spi_block (.clk, .reset_n, .enable, .masterMode, .spiMode, .lsbFirst,
        .auxPinSelect, .auxFirmwareSelectEnable, .auxIn, .txData, .txValid, .txReady,
        .rxRead, .statusRead, .rxData, .txEmpty, .rxFull, .byteDone, .rxOverflow,
        .txEmptyIrq, .sclkIn, .sclkOut, .sclkOeN, .mosiIn, .mosiOut, .misoIn, .misoOut);
    spi_far_end i_spi_far_end (.clk, .pol(spiMode[1]), .pha(spiMode[0]), .lsb(lsbFirst),
        .sclkOut, .mosiOut, .misoOut, .slvTx, .misoIn, .slvRx, .sclkIn, .mosiIn, .ssN);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic send(input logic [7:0] b);
        @(negedge clk);
        txData = b;
        txValid = 1'b1;
        for (int i = 0; i < 50 && txReady !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        txValid = 1'b0;
    endtask : send

    task automatic wait_full();
        for (int i = 0; i < 100 && rxFull !== 1'b1; i++) @(negedge clk);
        check(rxFull, 1'b1);
    endtask : wait_full

    task automatic read_rx();
        rxRead = 1'b1;
        @(negedge clk);
        rxRead = 1'b0;
    endtask : read_rx

    task automatic setup(input logic [1:0] m, input logic l, input logic mm);
        enable = 1'b0;
        spiMode = m;
        lsbFirst = l;
        masterMode = mm;
        repeat (3) @(negedge clk);
        if (mm) check(sclkOut, m[1]);
        i_spi_far_end.rearm();
        enable = 1'b1;
        @(negedge clk);
        check(txEmpty, 1'b1);
        check(txEmptyIrq, 1'b0);
    endtask : setup

    initial begin
        #50000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (2) @(negedge clk);
        check(txReady, 1'b1);
        check(rxData, 8'h00);
        check(misoOut, 1'b1);
        reset_n = 1'b1;
        foreach (rows[r]) begin
            slvTx = rows[r].sl;
            setup(rows[r].mode, rows[r].lsb, 1'b1);
            send(rows[r].tx);
            wait_full();
            check(rxData, rows[r].sl);
            check(byteDone, rows[r].mode[1]);
            check(slvRx, rows[r].tx);
            @(negedge clk);
            check(byteDone, 1'b1);
            check(txEmptyIrq, 1'b1);
            read_rx();
            check(rxFull, 1'b0);
            check(sclkOut, rows[r].mode[1]);
            check(sclkOeN, 1'b0);
        end
        // second byte queued early must follow without a gap and overrun the unread first
        slvTx = 8'h99;
        setup(2'h0, 1'b0, 1'b1);
        send(8'h11);
        send(8'h22);
        wait_full();
        for (int i = 0; i < 16 && rxOverflow !== 1'b1; i++) @(negedge clk);
        check(rxOverflow, 1'b1);
        repeat (4) @(negedge clk);
        check(slvRx, 8'h22);
        statusRead = 1'b1;
        @(negedge clk);
        statusRead = 1'b0;
        check(rxOverflow, 1'b0);
        // disable in mid-transfer
        setup(2'h2, 1'b0, 1'b1);
        send(8'h55);
        repeat (6) @(negedge clk);
        enable = 1'b0;
        repeat (2) @(negedge clk);
        check(sclkOut, 1'b1);
        check({txEmpty, rxFull, byteDone, rxOverflow, txEmptyIrq}, 8'h00);
        check(rxData, 8'h99);
        // staging buffer fills while disabled, then drains in order
        send(8'h61);
        send(8'h62);
        check(txReady, 1'b0);
        slvTx = 8'h24;
        setup(2'h1, 1'b0, 1'b1);
        wait_full();
        read_rx();
        wait_full();
        check(slvRx, 8'h62);
        check(rxData, 8'h24);
        check(txReady, 1'b1);
        // slave role, select from a pin
        auxPinSelect = 2'h2;
        for (int m = 0; m < 4; m += 3) begin
            setup(2'(m), m[0], 1'b0);
            check(misoOut, 1'b1);
            send(8'h96 ^ 8'(m));
            i_spi_far_end.master_xfer(8'h5a + 8'(m), mRx);
            check(rxData, 8'h5a + 8'(m));
            check(mRx, 8'h96 ^ 8'(m));
            check(sclkOeN, 1'b1);
            read_rx();
        end
        // firmware select: negated ignores the bus, asserted receives
        auxFirmwareSelectEnable = 1'b1;
        auxPinSelect = 2'h1;
        i_spi_far_end.master_xfer(8'hc5, mRx);
        check(mRx, 8'hff);
        check(rxFull, 1'b0);
        auxPinSelect = 2'h0;
        i_spi_far_end.master_xfer(8'h3a, mRx);
        check(rxData, 8'h3a);
        wrap_up();
    end
endmodule : testbench
